// ---- core/flash_lock_cmds.sv ----
// Purpose: lock bit, secret and reset command handling of a serial flash
// Assumes: mode 0 link, sampled by clk_i; link clock well below clk_i/4
// Notes:   nrst_i doubles as the hardware reset pin
`timescale 1ns/100ps
module flash_lock_cmds #(
	parameter int SPROG_CYC  = flash_lock_pkg::PP_CYC,  // secret program time
	parameter int PSUSP_CYC  = flash_lock_pkg::PSL_CYC, // program suspend latency
	parameter int ESUSP_CYC  = flash_lock_pkg::ESL_CYC, // erase suspend latency
	parameter int LOCK_CYC   = 64,                       // lock clear time
	parameter int UNLOCK_CYC = 64,                       // unlock compare time
	parameter int RESET_CYC  = 256,                      // software reset time
	parameter int ERASE_CYC  = 100000                    // erase time
) (
	input  wire logic       clk_i,            // core clock
	input  wire logic       nrst_i,           // sync reset / reset pin, low
	input  wire logic       sck_i,            // link clock pin
	input  wire logic       cs_n_i,           // chip select pin, low
	input  wire logic       si_i,             // serial data in pin
	input  wire logic       secret_mode_n_i,  // protection reg bit 2
	input  wire logic       bp_volatile_i,    // protect bits volatile
	input  wire logic [2:0] bp_nv_value_i,    // power-up protect bits
	input  wire logic       bp_load_i,        // protect bits write strobe
	input  wire logic [2:0] bp_wdata_i,       // protect bits write data
	input  wire logic       freeze_set_i,     // set freeze bit
	input  wire logic       cont_enter_i,     // enter continuous read
	input  wire logic       erase_start_i,    // start an erase
	input  wire logic       program_fail_i,   // program fault at end
	output logic            so_o,             // serial data out
	output logic            so_oe_o,          // serial out enable
	output logic            busy_flag_o,      // status busy
	output logic            write_latch_o,    // status write latch
	output logic            p_err_o,          // status program fail
	output logic            persistent_lock_bit_o, // lock register bit 0
	output logic            freeze_o,         // config freeze bit
	output logic [2:0]      block_protect_bits_o, // protect bits
	output logic            cont_mode_o,      // continuous read mode
	output logic            suspended_o       // op suspended
);
	import flash_lock_pkg::*;

	if (SPROG_CYC < 1 || PSUSP_CYC < 1 || ESUSP_CYC < 1 || LOCK_CYC < 1 || UNLOCK_CYC < 1 ||
			RESET_CYC < 1 || ERASE_CYC < 1 || ERASE_CYC >= 2**TW || SPROG_CYC >= 2**TW || LOCK_CYC >= 2**TW ||
			UNLOCK_CYC >= 2**TW || PSUSP_CYC >= 2**TW || ESUSP_CYC >= 2**TW || RESET_CYC >= 2**TW) begin : g_chk
		$error("timer count out of range");
	end

	typedef enum logic [1:0] {S_IDLE = 2'b00, S_CMD = 2'b01, S_BODY = 2'b10, S_READ = 2'b11} ser_t;
	typedef enum logic [2:0] {OP_NONE = 3'b000, OP_LOCK = 3'b001, OP_SPROG = 3'b010, OP_UNLK = 3'b011,
		OP_FAIL = 3'b100, OP_RESET = 3'b101, OP_ERASE = 3'b110, OP_SUSP = 3'b111} op_t;

	logic [2:0]          pins;
	logic                sck_q, cs_q;
	ser_t                st;
	op_t                 op, next_op;
	logic [6:0]          bit_cnt;
	logic [7:0]          cmd;
	logic [SECRET_W-1:0] pw_in, secret, rd_word;
	logic [5:0]          pos;
	logic                init_pend, rd_ok;
	op_timer_if          tmr ();

	pin_sync #(.W(3)) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({sck_i, cs_n_i, si_i}),
		.q_o    (pins)
	);
	op_timer u_tmr (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.t      (tmr.tmr)
	);

	wire sck_s    = pins[2];
	wire cs_s     = pins[1];
	wire si_s     = pins[0];
	wire sck_rise = sck_s & ~sck_q;
	wire sck_fall = ~sck_s & sck_q;
	wire cs_fall  = cs_q & ~cs_s;
	wire cs_rise  = cs_s & ~cs_q & (st != S_IDLE);
	wire [7:0] cmd_next = {cmd[6:0], si_s};
	wire idle     = (op == OP_NONE);
	wire at8      = cs_rise & (bit_cnt == CMD_END);
	wire at72     = cs_rise & (bit_cnt == BODY_END);
	wire mismatch = (pw_in != secret);
	wire [5:0] data_idx = 6'(bit_cnt - CMD_END);

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			sck_q <= 1'b1;   // level the synchroniser resets to, so no false edge
			cs_q  <= 1'b1;
		end else begin
			sck_q <= sck_s;
			cs_q  <= cs_s;
		end
	end

	// command decode at chip select rise; continuous read mode hides all but the exit
	logic go_wlset, go_sclr, go_lock, go_sprog, go_unlk, go_reset, go_exit, go_psusp, go_esusp;
	always_comb begin
		go_exit  = at8 & (cmd == CONT_READ_EXIT_CMD);
		go_wlset = at8 & ~cont_mode_o & idle & (cmd == WRITE_LATCH_SET_CMD);
		go_sclr  = at8 & ~cont_mode_o & (cmd == STATUS_CLEAR_CMD);
		go_reset = at8 & ~cont_mode_o & (cmd == SOFT_RESET_CMD);
		go_lock  = at8 & ~cont_mode_o & idle & write_latch_o & (cmd == LOCK_BIT_CLEAR_CMD);
		go_sprog = at72 & ~cont_mode_o & idle & write_latch_o & secret_mode_n_i
			& (cmd == SECRET_PROGRAM_CMD);
		go_unlk  = at72 & ~cont_mode_o & idle & (cmd == SECRET_UNLOCK_CMD);
		go_psusp = at8 & ~cont_mode_o & (cmd == PROG_SUSPEND_CMD);
		go_esusp = at8 & ~cont_mode_o & (cmd == ERASE_SUSPEND_CMD);
	end

	always_comb begin
		next_op = op;
		if (go_reset)
			next_op = OP_RESET;
		else if (go_sclr && op == OP_FAIL)
			next_op = OP_NONE;
		else if (go_psusp && (op == OP_LOCK || op == OP_SPROG))
			next_op = OP_SUSP;
		else if (go_esusp && op == OP_ERASE)
			next_op = OP_SUSP;
		else if (idle) begin
			if (go_lock)
				next_op = OP_LOCK;
			else if (go_sprog)
				next_op = OP_SPROG;
			else if (go_unlk)
				next_op = OP_UNLK;
			else if (erase_start_i)
				next_op = OP_ERASE;
		end else if (tmr.done && op != OP_FAIL)
			next_op = (op == OP_UNLK && mismatch) ? OP_FAIL : OP_NONE;
	end

	// a new timed op (re)loads the timer; the suspend reload cuts the old count short
	always_comb begin
		tmr.load  = (next_op != op) && (next_op != OP_NONE) && (next_op != OP_FAIL);
		tmr.count = TW'(1);
		unique case (next_op)
			OP_LOCK:  tmr.count = TW'(LOCK_CYC);
			OP_SPROG: tmr.count = TW'(SPROG_CYC);
			OP_UNLK:  tmr.count = TW'(UNLOCK_CYC);
			OP_RESET: tmr.count = TW'(RESET_CYC);
			OP_ERASE: tmr.count = TW'(ERASE_CYC);
			OP_SUSP:  tmr.count = (op == OP_ERASE) ? TW'(ESUSP_CYC) : TW'(PSUSP_CYC);
			OP_NONE, OP_FAIL: tmr.count = TW'(1);
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			op          <= OP_NONE;
			busy_flag_o <= 1'b0;
		end else begin
			op          <= next_op;
			busy_flag_o <= (next_op != OP_NONE);
		end
	end

	wire op_end = tmr.done & (next_op == OP_NONE | next_op == OP_FAIL) & ~tmr.load;

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			write_latch_o <= 1'b0;
		else if (go_wlset)
			write_latch_o <= 1'b1;
		else if (go_reset || (op_end && (op == OP_LOCK || op == OP_SPROG)))
			write_latch_o <= 1'b0;
	end

	// fail set wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			p_err_o <= 1'b0;
		else if (op_end && op == OP_SPROG && program_fail_i)
			p_err_o <= 1'b1;
		else if (op_end && op == OP_UNLK && mismatch)
			p_err_o <= 1'b1;
		else if (go_sclr || go_reset)
			p_err_o <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			secret <= SECRET_RESET;
		else if (op_end && op == OP_SPROG && !program_fail_i)
			secret <= pw_in;
	end

	// power-up lock value follows the chosen mode, caught one edge after release
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			init_pend             <= 1'b1;
			persistent_lock_bit_o <= 1'b0;
		end else begin
			init_pend <= 1'b0;
			if (init_pend)
				persistent_lock_bit_o <= secret_mode_n_i;
			else if (op_end && op == OP_UNLK && !mismatch)
				persistent_lock_bit_o <= 1'b1;
			else if (op_end && op == OP_LOCK)
				persistent_lock_bit_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			freeze_o <= 1'b0;
		else if (freeze_set_i)
			freeze_o <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			block_protect_bits_o <= 3'h0;
		else if (init_pend)
			block_protect_bits_o <= bp_nv_value_i;
		else if (go_reset && bp_volatile_i && !freeze_o)
			block_protect_bits_o <= bp_nv_value_i;
		else if (bp_load_i && !freeze_o)
			block_protect_bits_o <= bp_wdata_i;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			cont_mode_o <= 1'b0;
		else if (go_exit || go_reset)
			cont_mode_o <= 1'b0;
		else if (cont_enter_i)
			cont_mode_o <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			suspended_o <= 1'b0;
		else if (op_end && op == OP_SUSP)
			suspended_o <= 1'b1;
		else if (go_reset || (tmr.load && next_op != OP_SUSP))
			suspended_o <= 1'b0;
	end

	// frame tracking; the count saturates so overlong frames never look exact
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st      <= S_IDLE;
			bit_cnt <= 7'h00;
			cmd     <= 8'h00;
		end else if (cs_s) begin
			st <= S_IDLE;
		end else if (cs_fall) begin
			st      <= S_CMD;
			bit_cnt <= 7'h00;
		end else if (sck_rise && st != S_IDLE) begin
			if (bit_cnt != CNT_MAX)
				bit_cnt <= bit_cnt + 7'h01;
			if (st == S_CMD) begin
				cmd <= cmd_next;
				if (bit_cnt == CMD_END - 7'h01)
					st <= rd_ok ? S_READ : S_BODY;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			pw_in <= '0;
		else if (sck_rise && st == S_BODY && bit_cnt >= CMD_END && bit_cnt < BODY_END)
			pw_in[{data_idx[5:3], ~data_idx[2:0]}] <= si_s;
	end

	always_comb begin
		rd_ok = 1'b0;
		if (!cont_mode_o) begin
			unique case (cmd_next)
				STATUS_READ_CMD:   rd_ok = 1'b1;
				LOCK_BIT_READ_CMD: rd_ok = idle;
				SECRET_READ_CMD:   rd_ok = idle & secret_mode_n_i;
				default:           rd_ok = 1'b0;
			endcase
		end
	end

	// read word captured when the instruction completes; status and lock bytes replicate to 64 bits
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			rd_word <= '0;
		else if (sck_rise && st == S_CMD && bit_cnt == CMD_END - 7'h01) begin
			if (cmd_next == SECRET_READ_CMD)
				rd_word <= secret;
			else if (cmd_next == LOCK_BIT_READ_CMD)
				rd_word <= {8{7'h00, persistent_lock_bit_o}};
			else begin
				rd_word <= '0;
				for (int i = 0; i < 8; i++) begin
					rd_word[8*i+ST_BUSY]      <= busy_flag_o;
					rd_word[8*i+ST_WL]        <= write_latch_o;
					rd_word[8*i+ST_BP +: 3]   <= block_protect_bits_o;
					rd_word[8*i+ST_PERR]      <= p_err_o;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i || cs_s) begin
			so_o    <= 1'b0;
			so_oe_o <= 1'b0;
			pos     <= 6'h00;
		end else if (st == S_READ && sck_fall) begin
			so_oe_o <= 1'b1;
			so_o    <= rd_word[{pos[5:3], ~pos[2:0]}];
			pos     <= pos + 6'h01;
		end
	end
endmodule : flash_lock_cmds

// ---- core/flash_lock_pkg.sv ----
// Purpose: shared constants for the lock, secret and reset command block
// Assumes: 250 MHz core clock
// Notes:   timing counts derive from printed times
package flash_lock_pkg;
	localparam int CLK_MHZ   = 250;
	localparam int TW        = 24;                     // timer width
	localparam int PP_MAX_US = 750;                    // page-program max
	localparam int PP_CYC    = PP_MAX_US * CLK_MHZ;    // longest time, exact whole cycles
	localparam int PSL_US    = 40;                     // program suspend latency
	localparam int PSL_CYC   = PSL_US * CLK_MHZ;
	localparam int ESL_US    = 45;                     // erase suspend latency
	localparam int ESL_CYC   = ESL_US * CLK_MHZ;

	localparam int SECRET_W  = 64;
	localparam logic [6:0] CMD_END  = 7'h08;           // bits in an instruction
	localparam logic [6:0] BODY_END = 7'h48;           // instruction plus 64 bits
	localparam logic [6:0] CNT_MAX  = 7'h7f;

	localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
	localparam logic [7:0] STATUS_READ_CMD     = 8'h05;
	localparam logic [7:0] STATUS_CLEAR_CMD    = 8'h30;
	localparam logic [7:0] LOCK_BIT_READ_CMD   = 8'ha7;
	localparam logic [7:0] LOCK_BIT_CLEAR_CMD  = 8'ha6;
	localparam logic [7:0] SECRET_READ_CMD     = 8'he7;
	localparam logic [7:0] SECRET_PROGRAM_CMD  = 8'he8;
	localparam logic [7:0] SECRET_UNLOCK_CMD   = 8'he9;
	localparam logic [7:0] SOFT_RESET_CMD      = 8'hf0;
	localparam logic [7:0] CONT_READ_EXIT_CMD  = 8'hff;
	localparam logic [7:0] PROG_SUSPEND_CMD    = 8'h85;
	localparam logic [7:0] ERASE_SUSPEND_CMD   = 8'h75;

	localparam int ST_BUSY  = 0;                       // status byte layout
	localparam int ST_WL    = 1;
	localparam int ST_BP    = 2;
	localparam int ST_PERR  = 6;

	localparam logic [SECRET_W-1:0] SECRET_RESET = 64'hffff_ffff_ffff_ffff;
endpackage : flash_lock_pkg

// ---- core/op_timer_if.sv ----
// Purpose: start/finish handshake between command logic and op timer
// Assumes: both ends on clk_i
// Notes:   load wins over a running count
`timescale 1ns/100ps
interface op_timer_if;
	import flash_lock_pkg::*;
	logic          load;
	logic [TW-1:0] count;
	logic          done;
	modport ctrl (output load, output count, input done);
	modport tmr  (input load, input count, output done);
endinterface : op_timer_if

// ---- core/pin_sync.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes:   only the second stage is visible
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_i,   // core clock
	input  wire logic         nrst_i,  // sync reset, low
	input  wire logic [W-1:0] d_i,     // raw pins
	output logic      [W-1:0] q_o      // synchronised
);
	logic [W-1:0] meta;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta <= '1;
			q_o  <= '1;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : pin_sync

// ---- core/op_timer.sv ----
// Purpose: down counter timing self-timed operations
// Assumes: count of at least one
// Notes:   done pulses count edges after the edge that takes load
`timescale 1ns/100ps
module op_timer (
	input  wire logic clk_i,    // core clock
	input  wire logic nrst_i,   // sync reset, low
	op_timer_if.tmr   t         // load/done handshake
);
	import flash_lock_pkg::*;
	logic [TW-1:0] cnt;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cnt    <= '0;
			t.done <= 1'b0;
		end else if (t.load) begin
			cnt    <= t.count;
			t.done <= 1'b0;
		end else begin
			if (cnt != '0)
				cnt <= cnt - 1'b1;
			t.done <= (cnt == TW'(1));
		end
	end
endmodule : op_timer

// ---- tb/flash_lock_cmds_props.sv ----
// Purpose: concurrent checks on the lock, secret and reset command block ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every flash_lock_cmds instance
`timescale 1ns/100ps
module flash_lock_cmds_props (
	input wire logic       clk_i,                 // core clock
	input wire logic       nrst_i,                // sync reset, low
	input wire logic       cs_n_i,                // chip select
	input wire logic       secret_mode_n_i,       // secret mode not chosen
	input wire logic [2:0] bp_nv_value_i,         // power-up protect
	input wire logic       so_oe_o,               // out enable
	input wire logic       busy_flag_o,           // busy
	input wire logic       write_latch_o,         // write latch
	input wire logic       p_err_o,               // program fail
	input wire logic       persistent_lock_bit_o, // lock bit
	input wire logic       freeze_o,              // freeze bit
	input wire logic [2:0] block_protect_bits_o,  // protect bits
	input wire logic       cont_mode_o,           // continuous read
	input wire logic       suspended_o            // suspended
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rst_clear;
		$rose(nrst_i) |-> !busy_flag_o && !write_latch_o && !p_err_o && !freeze_o && !so_oe_o;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("flags not clear out of reset");
	property p_init;
		$rose(nrst_i) |-> ##2 persistent_lock_bit_o == secret_mode_n_i && block_protect_bits_o == bp_nv_value_i;
	endproperty
	a_init: assert property (p_init) else $error("lock or protect bits not loaded");
	property p_busy_cs;
		$rose(busy_flag_o) |-> cs_n_i && $past(cs_n_i);
	endproperty
	a_busy_cs: assert property (p_busy_cs) else $error("busy rose inside a frame");
	property p_done_latch;
		$fell(busy_flag_o) |-> ##1 (suspended_o || !write_latch_o);
	endproperty
	a_done_latch: assert property (p_done_latch) else $error("write latch kept after operation");
	property p_fail_stuck;
		(busy_flag_o && p_err_o && cs_n_i) [*8] |=> busy_flag_o;
	endproperty
	a_fail_stuck: assert property (p_fail_stuck) else $error("busy left fail state alone");
	property p_oe_off;
		cs_n_i [*6] |-> !so_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("serial out driven outside frame");
	property p_susp_idle;
		$rose(suspended_o) |-> !busy_flag_o;
	endproperty
	a_susp_idle: assert property (p_susp_idle) else $error("suspended while busy");
	property p_freeze_hold;
		freeze_o |=> freeze_o;
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("freeze bit dropped");
	property p_lock_clear;
		$fell(persistent_lock_bit_o) |-> !busy_flag_o && !write_latch_o;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock cleared out of step");
	property p_bp_frozen;
		freeze_o && $past(freeze_o) |-> $stable(block_protect_bits_o);
	endproperty
	a_bp_frozen: assert property (p_bp_frozen) else $error("protect bits moved while frozen");
	c_fail: cover property (busy_flag_o && p_err_o);
	c_susp: cover property ($rose(suspended_o));
	c_cont: cover property ($fell(cont_mode_o));
endmodule : flash_lock_cmds_props
bind flash_lock_cmds flash_lock_cmds_props props_u (
	.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .secret_mode_n_i(secret_mode_n_i),
	.bp_nv_value_i(bp_nv_value_i), .so_oe_o(so_oe_o), .busy_flag_o(busy_flag_o),
	.write_latch_o(write_latch_o), .p_err_o(p_err_o), .persistent_lock_bit_o(persistent_lock_bit_o),
	.freeze_o(freeze_o), .block_protect_bits_o(block_protect_bits_o), .cont_mode_o(cont_mode_o),
	.suspended_o(suspended_o));

// ---- tb/spi_host_model.sv ----
// Purpose: host end of the serial link, drives chip select and link clock
// Assumes: mode 0, 32 ns link period, paced by delays after one bench clock edge
// Notes:   samples late in the high phase to clear the device pin sync delay
`timescale 1ns/100ps
module spi_host_model (
	input  wire logic clk_i,  // bench clock
	input  wire logic so_i,   // device serial out
	output logic      sck_o,  // link clock, low between frames
	output logic      cs_n_o, // chip select, low
	output logic      si_o    // serial data to device
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// bits leave from bit 71 down; rx keeps the last 64 bits seen
	task automatic xfer(input logic [71:0] bits, input int n, output logic [63:0] rx);
		rx = '0;
		@(posedge clk_i);
		#1 cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			si_o = (i < 72) ? bits[71-i] : 1'b0;
			#16 sck_o = 1'b1;
			#15 rx = {rx[62:0], so_i};
			#1 sck_o = 1'b0;
		end
		#16 cs_n_o = 1'b1;
		si_o = ~si_o; // a released line must not keep its last bit
		#32;
	endtask : xfer
endmodule : spi_host_model

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the lock, secret and reset commands
// Assumes: host model paces the link at 32 ns per bit
// Notes:   long operation times shortened through parameters
`timescale 1ns/100ps
module tb;
	import flash_lock_pkg::*;
	localparam int          PROG  = 400;
	localparam logic [63:0] PW    = 64'h0123_4567_89ab_cdef;
	logic        clk_i = 1'b0, nrst_i = 1'b0, smode_n = 1'b1, bp_vol = 1'b1, bp_ld = 1'b0;
	logic        frz_set = 1'b0, cont_set = 1'b0, erase = 1'b0, pfail = 1'b0, oe_seen = 1'b0;
	logic        sck, cs_n, si, so, so_oe, busy, wl, perr, plock, frz, cmode, susp;
	logic [2:0]  bp;
	logic [63:0] rx;
	int          fail_count = 0, compares = 0, cycles = 0;
	// an undriven serial out shows the inverse of its last value
	spi_host_model host_u (.clk_i(clk_i), .so_i(so_oe ? so : ~so), .sck_o(sck), .cs_n_o(cs_n), .si_o(si));
	flash_lock_cmds #(.SPROG_CYC(PROG), .PSUSP_CYC(20), .ESUSP_CYC(25), .ERASE_CYC(400)) dut_u (
		.clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .secret_mode_n_i(smode_n),
		.bp_volatile_i(bp_vol), .bp_nv_value_i(3'h2), .bp_load_i(bp_ld), .bp_wdata_i(3'h5),
		.freeze_set_i(frz_set), .cont_enter_i(cont_set), .erase_start_i(erase), .program_fail_i(pfail),
		.so_o(so), .so_oe_o(so_oe), .busy_flag_o(busy), .write_latch_o(wl), .p_err_o(perr),
		.persistent_lock_bit_o(plock), .freeze_o(frz), .block_protect_bits_o(bp),
		.cont_mode_o(cmode), .suspended_o(susp));
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (so_oe === 1'b1) oe_seen <= 1'b1;
		if (cycles == 30000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic send(input logic [7:0] c, input logic [63:0] d, input int n);
		host_u.xfer({c, d}, n, rx);
	endtask : send
	// bounded poll of busy before the next command
	task automatic idle(input int lim);
		int took = 0;
		while (busy !== 1'b0 && took < lim) begin
			tick(1);
			took++;
		end
		check(took < lim, 1'b1);
	endtask : idle
	task automatic soft_reset;
		send(CONT_READ_EXIT_CMD, 64'h0, 8);
		send(SOFT_RESET_CMD, 64'h0, 8);
	endtask : soft_reset
	task automatic close_out;
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		tick(16);
		check({so_oe, busy, wl, perr, plock, frz, cmode, susp}, 8'h00);
		nrst_i = 1'b1;
		tick(4);
		check({plock, bp}, 4'ha);
		send(LOCK_BIT_READ_CMD, 64'h0, 24);
		check(rx[15:0], 16'h0101);
		send(LOCK_BIT_CLEAR_CMD, 64'h0, 8);
		check({busy, plock}, 2'b01);
		send(WRITE_LATCH_SET_CMD, 64'h0, 8);
		send(LOCK_BIT_CLEAR_CMD, 64'h0, 9);
		check({busy, wl, plock}, 3'b011);
		send(LOCK_BIT_CLEAR_CMD, 64'h0, 8);
		check(busy, 1'b1);
		idle(100);
		check({wl, plock}, 2'b00);
		send(LOCK_BIT_READ_CMD, 64'h0, 24);
		check(rx[15:0], 16'h0000);
		$display("test lock done");
		send(WRITE_LATCH_SET_CMD, 64'h0, 8);
		send(SECRET_PROGRAM_CMD, PW, 72);
		check(busy, 1'b1);
		send(STATUS_READ_CMD, 64'h0, 16);
		check(rx[7:0], 8'h0b);
		idle(PROG);
		check({wl, perr}, 2'b00);
		oe_seen = 1'b0;
		for (int n = 72; n <= 136; n += 64) begin
			send(SECRET_READ_CMD, 64'h0, n);
			check(rx, PW);
		end
		check(oe_seen, 1'b1);
		$display("test secret program done");
		send(SECRET_UNLOCK_CMD, ~PW, 72);
		tick(100);
		check({busy, perr}, 2'b11);
		send(STATUS_READ_CMD, 64'h0, 16);
		check(rx[7:0], 8'h49);
		oe_seen = 1'b0;
		send(LOCK_BIT_READ_CMD, 64'h0, 24);
		check(oe_seen, 1'b0);
		send(STATUS_CLEAR_CMD, 64'h0, 8);
		check({busy, perr}, 2'b00);
		send(SECRET_UNLOCK_CMD, PW, 71);
		check(busy, 1'b0);
		send(SECRET_UNLOCK_CMD, PW, 72);
		idle(100);
		check({plock, perr}, 2'b10);
		$display("test unlock done");
		pfail = 1'b1;
		send(WRITE_LATCH_SET_CMD, 64'h0, 8);
		send(SECRET_PROGRAM_CMD, ~PW, 72);
		idle(PROG);
		check({wl, perr}, 2'b01);
		pfail = 1'b0;
		bp_ld = 1'b1;
		tick(1);
		bp_ld = 1'b0;
		frz_set = 1'b1;
		tick(1);
		frz_set = 1'b0;
		send(WRITE_LATCH_SET_CMD, 64'h0, 8);
		soft_reset();
		check({busy, wl, perr}, 3'b100);
		idle(300);
		check({frz, plock, bp}, 5'h1d);
		nrst_i = 1'b0;
		tick(5);
		nrst_i = 1'b1;
		tick(4);
		check({frz, plock}, 2'b01);
		for (int v = 0; v < 2; v++) begin
			bp_vol = v[0];
			bp_ld = 1'b1;
			tick(1);
			bp_ld = 1'b0;
			soft_reset();
			idle(300);
			check(bp, v ? 3'h2 : 3'h5);
		end
		$display("test resets done");
		cont_set = 1'b1;
		tick(1);
		cont_set = 1'b0;
		tick(2);
		check(cmode, 1'b1);
		send(WRITE_LATCH_SET_CMD, 64'h0, 8);
		check(wl, 1'b0);
		send(CONT_READ_EXIT_CMD, 64'h0, 8);
		check(cmode, 1'b0);
		for (int e = 0; e < 2; e++) begin
			erase = e[0];
			if (e == 0) send(WRITE_LATCH_SET_CMD, 64'h0, 8);
			if (e == 0) send(SECRET_PROGRAM_CMD, PW, 72);
			tick(1);
			erase = 1'b0;
			send(e ? ERASE_SUSPEND_CMD : PROG_SUSPEND_CMD, 64'h0, 8);
			idle(e ? 25 : 20);
			check(susp, 1'b1);
			soft_reset();
			idle(300);
			check(susp, 1'b0);
		end
		$display("test suspend done");
		smode_n = 1'b0;
		oe_seen = 1'b0;
		send(SECRET_READ_CMD, 64'h0, 72);
		check(oe_seen, 1'b0);
		send(WRITE_LATCH_SET_CMD, 64'h0, 8);
		send(SECRET_PROGRAM_CMD, PW, 72);
		check(busy, 1'b0);
		$display("test secret mode done");
		close_out();
	end
endmodule : tb
